// File: logic/sgai_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SGAI_MAP_SVH
`define SGAI_MAP_SVH

`define SGAI_OFS_GPIO0_CFG 8'h0D
`define SGAI_OFS_GPIO12_CFG 8'h0E
`define SGAI_OFS_GPIO3R5_CFG 8'h0F
`define SGAI_OFS_R6R7_CFG 8'h10
`define SGAI_OFS_R8_CFG 8'h11
`define SGAI_OFS_VIDEO 8'h12
`define SGAI_OFS_IN_RB 8'h1C
`define SGAI_OFS_IN_RB8 8'h1D
`define SGAI_OFS_PAT_ADDR 8'h66
`define SGAI_OFS_PAT_DATA 8'h67
`define SGAI_OFS_AUDIO_CTRL 8'h70
`define SGAI_OFS_STATUS 8'h71

`define SGAI_NIB_OUT_L 4'h1
`define SGAI_NIB_OUT_H 4'h9
`define SGAI_NIB_INPUT 4'h3
`define SGAI_NIB_BACK 4'h5

`define SGAI_VIDEO_18B_BIT 2
`define SGAI_AUD_ISL_DIS_BIT 0
`define SGAI_AUD_SURR_BIT 1
`define SGAI_AUD_FOURCH_BIT 2
`define SGAI_AUD_REGEN_BIT 3

`define SGAI_CFG_RST 8'h00
`define SGAI_VIDEO_RST 8'h00
`define SGAI_AUDIO_RST 8'h00
`define SGAI_PAT_RST 8'h00

`define SGAI_KIND_GPIO 2'h0
`define SGAI_KIND_AUDIO 2'h1

`define SGAI_CLK_MHZ 125
`define SGAI_PD_HOLD_US 1500
`define SGAI_PD_HOLD_CYC (`SGAI_PD_HOLD_US * `SGAI_CLK_MHZ)

`endif

// File: logic/sgai_pkg.sv
// Types shared by the GPIO and audio input block
package sgai_pkg;
	typedef enum logic [2:0] {
		SGAI_GM_OFF = 3'h0,
		SGAI_GM_OUT_L = 3'h1,
		SGAI_GM_OUT_H = 3'h2,
		SGAI_GM_INPUT = 3'h3,
		SGAI_GM_BACK = 3'h4
	} sgai_gpio_mode_t;

	typedef enum logic [1:0] {
		SGAI_AM_OFF = 2'h0,
		SGAI_AM_ISLAND = 2'h1,
		SGAI_AM_FRAME = 2'h2,
		SGAI_AM_SURROUND = 2'h3
	} sgai_audio_mode_t;

	typedef logic [15:0] sgai_word_t;
endpackage

// File: logic/sgai_fifo.sv
// Synchronous FIFO with a registered output stage
module sgai_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// Drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;

	wire push = i_valid && (cnt_ff != FULL_CNT);
	wire can_load = !out_valid_ff || i_ready;
	wire pop = can_load && (cnt_ff != '0);
	wire [CW-1:0] nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

	assign o_ready = (cnt_ff != FULL_CNT);
	assign o_valid = out_valid_ff;
	assign o_data = out_data_ff;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + AW'(1);
				out_data_ff <= mem[rd_ptr_ff];
			end
			if (can_load) begin
				out_valid_ff <= pop;
			end
		end
	end
endmodule

// File: logic/sgai_top.sv
// GPIO and audio input control of the serializer, with link FIFO
//
// Function
// R01 - Pin GPIOs forward inputs or back-channel outputs
// R02 - GPIO2/3 share pins with audio C/D
// R03 - Older deserializer needs 18-bit mode for GPIOs
// R04 - 18-bit setting sent to deserializer automatically
// R05 - Nibble 3 forward input, 5 back output
// R06 - Local nibble 1 low, 9 high, 3 input
// R07 - Input levels read at 1C and 1D
// R08 - Pin GPIO levels readable, local outputs possible
// R09 - Register GPIOs 5-8 local only
// R10 - Enabled register GPIO overrides audio input
// R11 - Local and remote register ports both reach GPIOs
// R12 - Register GPIO state never sent over link
// R13 - Audio bit clock from 1 to 13 MHz
// R14 - No audio in backward compatibility mode
// R15 - Older deserializer: A in 24-bit, A+B in 18-bit
// R16 - Default audio transport is data islands
// R17 - Islands off: frame transport, A or A+B
// R18 - Surround only islands with newer deserializer
// R19 - Repeater surround propagates using data islands
// R20 - Repeater four-channel A+B set per device
// R21 - Repeater may regenerate audio from pins
// R22 - Indirect pattern registers at 66 and 67
// R23 - Power-down low resets all control registers
// R24 - Power-down held low at least 1.5 ms
// R25 - GPIO inputs pass two-flop synchronizer
`include "sgai_map.svh"
module sgai_top
	import sgai_pkg::*;
#(
	parameter logic [17:0] PD_HOLD_CYC = 18'(`SGAI_PD_HOLD_CYC)
) (
	// Clock, reset and power-down
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_POWER_DOWN_N,
	// Local register port
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	output logic O_REG_RVALID,
	// Remote register port from the back control channel
	input wire logic I_RMT_WR,
	input wire logic I_RMT_RD,
	input wire logic [7:0] I_RMT_ADDR,
	input wire logic [7:0] I_RMT_WDATA,
	output logic [7:0] O_RMT_RDATA,
	output logic O_RMT_RVALID,
	output logic O_RMT_BUSY,
	// Pin GPIOs 0..3 (2 and 3 carry audio C and D)
	input wire logic [3:0] I_GPIO,
	output logic [3:0] O_GPIO,
	output logic [3:0] O_GPIO_OE,
	// Register GPIO pins 5..8 (5 and 6 carry audio A and B)
	input wire logic [3:0] I_REGPIN,
	output logic [3:0] O_REGPIN,
	output logic [3:0] O_REGPIN_OE,
	// Audio clocks
	input wire logic I_AUDIO_CLK,
	input wire logic I_AUDIO_WC,
	// System straps and partner state
	input wire logic I_LEGACY_COMPAT_MODE,
	input wire logic I_OLDER_DESER,
	input wire logic I_REPEATER_MODE,
	input wire logic I_UP_SURROUND,
	input wire logic [3:0] I_BC_GPIO,
	// Forward link words
	output logic O_LINK_VALID,
	input wire logic I_LINK_READY,
	output logic [15:0] O_LINK_DATA,
	// Pattern generator indirect write
	output logic O_PAT_WE,
	output logic [7:0] O_PAT_ADDR,
	output logic [7:0] O_PAT_DATA
);
	////////////////////////////////////////////////////////////////////////
	// Reset and nibble decode

	// Power-down acts as a synchronous reset of every control register
	wire rst = I_SRST || !I_POWER_DOWN_N; // R23

	function automatic sgai_gpio_mode_t nib_mode(input logic [3:0] nib);
		sgai_gpio_mode_t m;
		m = SGAI_GM_OFF;
		if (nib == `SGAI_NIB_OUT_L) m = SGAI_GM_OUT_L; // R06
		if (nib == `SGAI_NIB_OUT_H) m = SGAI_GM_OUT_H; // R06
		if (nib == `SGAI_NIB_INPUT) m = SGAI_GM_INPUT; // R05
		if (nib == `SGAI_NIB_BACK) m = SGAI_GM_BACK; // R05
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register port arbitration

	logic rmt_pend_ff;
	logic rmt_wr_ff;
	logic [7:0] rmt_addr_ff;
	logic [7:0] rmt_wdata_ff;
	wire loc_act = I_REG_WR || I_REG_RD;
	// Local port has priority; a remote request waits in one slot
	wire rmt_go = rmt_pend_ff && !loc_act; // R11
	wire acc_wr = loc_act ? I_REG_WR : (rmt_go && rmt_wr_ff);
	wire acc_rd = loc_act ? I_REG_RD : (rmt_go && !rmt_wr_ff);
	wire [7:0] acc_addr = loc_act ? I_REG_ADDR : rmt_addr_ff;
	wire [7:0] acc_wdata = loc_act ? I_REG_WDATA : rmt_wdata_ff;
	wire rmt_take = (I_RMT_WR || I_RMT_RD) && (!rmt_pend_ff || rmt_go);

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			rmt_pend_ff <= 1'b0;
			rmt_wr_ff <= 1'b0;
			rmt_addr_ff <= 8'h00;
			rmt_wdata_ff <= 8'h00;
		end else begin
			rmt_pend_ff <= rmt_take || (rmt_pend_ff && !rmt_go);
			if (rmt_take) begin
				rmt_wr_ff <= I_RMT_WR;
				rmt_addr_ff <= I_RMT_ADDR;
				rmt_wdata_ff <= I_RMT_WDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	logic [7:0] cfg_ff [0:4];
	logic [7:0] video_ff;
	logic [7:0] audio_ff;
	logic [7:0] pat_addr_ff;
	logic [7:0] pat_mem [0:255];

	wire cfg_hit = (acc_addr >= `SGAI_OFS_GPIO0_CFG) && (acc_addr <= `SGAI_OFS_R8_CFG);
	wire [2:0] cfg_idx = 3'(acc_addr - `SGAI_OFS_GPIO0_CFG);
	wire pat_data_wr = acc_wr && (acc_addr == `SGAI_OFS_PAT_DATA); // R22

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			for (int i = 0; i < 5; i++) begin
				cfg_ff[i] <= `SGAI_CFG_RST;
			end
			video_ff <= `SGAI_VIDEO_RST;
			audio_ff <= `SGAI_AUDIO_RST;
			pat_addr_ff <= `SGAI_PAT_RST;
		end else if (acc_wr) begin
			if (cfg_hit) begin
				cfg_ff[cfg_idx] <= acc_wdata;
			end
			if (acc_addr == `SGAI_OFS_VIDEO) video_ff <= acc_wdata;
			if (acc_addr == `SGAI_OFS_AUDIO_CTRL) audio_ff <= acc_wdata;
			if (acc_addr == `SGAI_OFS_PAT_ADDR) pat_addr_ff <= acc_wdata; // R22
		end
	end

	// Indirect space is storage only; it is not cleared by reset
	always_ff @(posedge I_CLK) begin
		if (pat_data_wr) begin
			pat_mem[pat_addr_ff] <= acc_wdata; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronizers

	// Bits: 3:0 pin GPIOs, 7:4 register pins, 8 bit clock, 9 word clock
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic aclk_d_ff;
	always_ff @(posedge I_CLK) begin
		if (rst) begin
			sync1_ff <= 10'h000;
			sync2_ff <= 10'h000;
			aclk_d_ff <= 1'b0;
		end else begin
			sync1_ff <= {I_AUDIO_WC, I_AUDIO_CLK, I_REGPIN, I_GPIO}; // R25
			sync2_ff <= sync1_ff; // R25
			aclk_d_ff <= sync2_ff[8];
		end
	end

	wire [3:0] gpio_lvl = sync2_ff[3:0];
	wire [3:0] regpin_lvl = sync2_ff[7:4];
	wire aclk_rise = sync2_ff[8] && !aclk_d_ff;

	////////////////////////////////////////////////////////////////////////
	// GPIO modes and pin drive

	wire mode18 = video_ff[`SGAI_VIDEO_18B_BIT];
	// Link GPIO functions are dead in compatibility mode or mis-set pairing
	wire link_ok = !I_LEGACY_COMPAT_MODE && (!I_OLDER_DESER || mode18); // R03

	wire [3:0] nib [0:7];
	assign nib[0] = cfg_ff[0][3:0];
	assign nib[1] = cfg_ff[1][3:0];
	assign nib[2] = cfg_ff[1][7:4];
	assign nib[3] = cfg_ff[2][3:0];
	assign nib[4] = cfg_ff[2][7:4];
	assign nib[5] = cfg_ff[3][3:0];
	assign nib[6] = cfg_ff[3][7:4];
	assign nib[7] = cfg_ff[4][3:0];

	wire [7:0] pin_lvl = {regpin_lvl, gpio_lvl};
	wire [7:0] pin_en;
	wire [7:0] pin_oe;
	wire [7:0] pin_out;
	wire [3:0] fwd_en;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			wire sgai_gpio_mode_t m = nib_mode(nib[g]);
			// Register GPIOs have no link path, so back mode drives nothing there
			wire back = (g < 4) && (m == SGAI_GM_BACK) && link_ok; // R01 R09 R12
			assign pin_en[g] = (m != SGAI_GM_OFF);
			assign pin_oe[g] = (m == SGAI_GM_OUT_L) || (m == SGAI_GM_OUT_H) || back; // R06 R08
			assign pin_out[g] = (m == SGAI_GM_OUT_H) || (back && I_BC_GPIO[g % 4]); // R01
			if (g < 4) begin : g_fwd
				assign fwd_en[g] = (m == SGAI_GM_INPUT) && link_ok; // R01 R05
			end
		end
	endgenerate

	logic [3:0] gpio_o_ff;
	logic [3:0] gpio_oe_ff;
	logic [3:0] regpin_o_ff;
	logic [3:0] regpin_oe_ff;

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			gpio_o_ff <= 4'h0;
			gpio_oe_ff <= 4'h0;
			regpin_o_ff <= 4'h0;
			regpin_oe_ff <= 4'h0;
		end else begin
			gpio_o_ff <= pin_out[3:0];
			gpio_oe_ff <= pin_oe[3:0];
			regpin_o_ff <= pin_out[7:4]; // R09
			regpin_oe_ff <= pin_oe[7:4]; // R09
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Audio transport selection

	wire rep_surr = I_REPEATER_MODE && I_UP_SURROUND; // R19
	wire surr_req = audio_ff[`SGAI_AUD_SURR_BIT] || rep_surr; // R19
	// Upstream surround forces data islands back on
	wire isl_dis = audio_ff[`SGAI_AUD_ISL_DIS_BIT] && !rep_surr; // R19
	wire [3:0] older_cap = mode18 ? 4'h3 : 4'h1; // R15

	sgai_audio_mode_t amode;
	assign amode = I_LEGACY_COMPAT_MODE ? SGAI_AM_OFF : // R14
		isl_dis ? SGAI_AM_FRAME : // R17
		(surr_req && !I_OLDER_DESER) ? SGAI_AM_SURROUND : // R18
		SGAI_AM_ISLAND; // R16

	wire [3:0] frame_mask = I_OLDER_DESER ? older_cap : 4'h1; // R17 R15
	// Two-input four-channel is a local setting in each repeater node
	wire [3:0] isl_mask = I_OLDER_DESER ? older_cap :
		(audio_ff[`SGAI_AUD_FOURCH_BIT] ? 4'h3 : 4'h1); // R15 R20
	wire [3:0] mode_mask = (amode == SGAI_AM_OFF) ? 4'h0 :
		(amode == SGAI_AM_FRAME) ? frame_mask :
		(amode == SGAI_AM_SURROUND) ? 4'hF : isl_mask; // R18
	// Enabled GPIO functions take the shared audio pins away
	wire [3:0] pin_free = ~{pin_en[3], pin_en[2], pin_en[5], pin_en[4]}; // R02 R10
	wire [3:0] lane_mask = mode_mask & pin_free;
	wire [3:0] lane_lvl = {gpio_lvl[3], gpio_lvl[2], regpin_lvl[1], regpin_lvl[0]}; // R02
	// A repeater relays island audio unless told to resample its pins
	wire use_pins = !I_REPEATER_MODE || audio_ff[`SGAI_AUD_REGEN_BIT]; // R21
	wire aud_sample = aclk_rise && use_pins && (lane_mask != 4'h0);

	////////////////////////////////////////////////////////////////////////
	// Link words and FIFO

	// GPIO word: kind, forward enables, 18-bit flag, forward levels
	wire [8:0] gpio_cur = {fwd_en, mode18, fwd_en & gpio_lvl}; // R01 R04
	wire sgai_word_t aud_cur = {`SGAI_KIND_AUDIO, 7'h00, amode, sync2_ff[9],
		lane_lvl & lane_mask};

	logic [8:0] gpio_sent_ff;
	logic [8:0] gpio_word_ff;
	logic gpio_pend_ff;
	logic aud_pend_ff;
	sgai_word_t aud_word_ff;
	logic ovf_ff;
	wire fifo_ready;
	wire fifo_valid = gpio_pend_ff || aud_pend_ff;
	wire sgai_word_t fifo_din = gpio_pend_ff ?
		{`SGAI_KIND_GPIO, 5'h00, gpio_word_ff} : aud_word_ff;
	wire gpio_acc = gpio_pend_ff && fifo_ready;
	wire aud_acc = !gpio_pend_ff && aud_pend_ff && fifo_ready;
	wire gpio_new = !gpio_pend_ff && (gpio_cur != gpio_sent_ff);
	// A sample that finds the slot still full is lost and flagged
	wire aud_lost = aud_sample && aud_pend_ff && !aud_acc;

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			gpio_sent_ff <= 9'h000;
			gpio_word_ff <= 9'h000;
			gpio_pend_ff <= 1'b0;
			aud_pend_ff <= 1'b0;
			aud_word_ff <= 16'h0000;
		end else begin
			if (gpio_new) begin
				gpio_word_ff <= gpio_cur;
			end
			if (gpio_acc) begin
				gpio_sent_ff <= gpio_word_ff;
			end
			gpio_pend_ff <= gpio_new || (gpio_pend_ff && !gpio_acc);
			if (aud_sample && (!aud_pend_ff || aud_acc)) begin
				aud_word_ff <= aud_cur;
			end
			aud_pend_ff <= aud_sample || (aud_pend_ff && !aud_acc);
		end
	end

	sgai_fifo #(
		.WIDTH(16),
		.DEPTH(16)
	) u_fifo (
		.i_clk(I_CLK),
		.i_rst(rst),
		.i_valid(fifo_valid),
		.o_ready(fifo_ready),
		.i_data(fifo_din),
		.o_valid(O_LINK_VALID),
		.i_ready(I_LINK_READY),
		.o_data(O_LINK_DATA)
	);

	////////////////////////////////////////////////////////////////////////
	// Power-down hold monitor

	// Runs on the plain reset so a short pulse is still seen afterwards
	logic [17:0] pd_cnt_ff;
	logic pd_n_d_ff;
	logic pd_short_ff;
	wire pd_rise = I_POWER_DOWN_N && !pd_n_d_ff;
	wire stat_rd = acc_rd && (acc_addr == `SGAI_OFS_STATUS);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			pd_cnt_ff <= 18'h00000;
			pd_n_d_ff <= 1'b1;
			pd_short_ff <= 1'b0;
		end else begin
			pd_n_d_ff <= I_POWER_DOWN_N;
			if (I_POWER_DOWN_N) begin
				pd_cnt_ff <= 18'h00000;
			end else if (pd_cnt_ff != PD_HOLD_CYC) begin
				pd_cnt_ff <= pd_cnt_ff + 18'h00001;
			end
			pd_short_ff <= (pd_rise && (pd_cnt_ff != PD_HOLD_CYC)) ||
				(pd_short_ff && !stat_rd); // R24
		end
	end

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			ovf_ff <= 1'b0;
		end else begin
			ovf_ff <= aud_lost || (ovf_ff && !stat_rd);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data and outputs

	wire [7:0] in_rb = {regpin_lvl[2:0], 1'b0, gpio_lvl}; // R07 R08
	wire [7:0] in_rb8 = {7'h00, regpin_lvl[3]}; // R07
	wire [7:0] status = {lane_mask, amode, pd_short_ff, ovf_ff};
	wire [7:0] rd_mux = cfg_hit ? cfg_ff[cfg_idx] :
		(acc_addr == `SGAI_OFS_VIDEO) ? video_ff :
		(acc_addr == `SGAI_OFS_IN_RB) ? in_rb :
		(acc_addr == `SGAI_OFS_IN_RB8) ? in_rb8 :
		(acc_addr == `SGAI_OFS_PAT_ADDR) ? pat_addr_ff :
		(acc_addr == `SGAI_OFS_PAT_DATA) ? pat_mem[pat_addr_ff] :
		(acc_addr == `SGAI_OFS_AUDIO_CTRL) ? audio_ff :
		(acc_addr == `SGAI_OFS_STATUS) ? status : 8'h00;

	logic [7:0] reg_rdata_ff;
	logic reg_rvalid_ff;
	logic [7:0] rmt_rdata_ff;
	logic rmt_rvalid_ff;
	logic pat_we_ff;
	logic [7:0] pat_a_ff;
	logic [7:0] pat_d_ff;

	always_ff @(posedge I_CLK) begin
		if (rst) begin
			reg_rdata_ff <= 8'h00;
			reg_rvalid_ff <= 1'b0;
			rmt_rdata_ff <= 8'h00;
			rmt_rvalid_ff <= 1'b0;
			pat_we_ff <= 1'b0;
			pat_a_ff <= 8'h00;
			pat_d_ff <= 8'h00;
		end else begin
			reg_rvalid_ff <= loc_act && I_REG_RD;
			rmt_rvalid_ff <= !loc_act && acc_rd; // R11
			if (loc_act && I_REG_RD) reg_rdata_ff <= rd_mux;
			if (!loc_act && acc_rd) rmt_rdata_ff <= rd_mux;
			pat_we_ff <= pat_data_wr;
			if (pat_data_wr) begin
				pat_a_ff <= pat_addr_ff;
				pat_d_ff <= acc_wdata;
			end
		end
	end

	assign O_REG_RDATA = reg_rdata_ff;
	assign O_REG_RVALID = reg_rvalid_ff;
	assign O_RMT_RDATA = rmt_rdata_ff;
	assign O_RMT_RVALID = rmt_rvalid_ff;
	assign O_RMT_BUSY = rmt_pend_ff;
	assign O_GPIO = gpio_o_ff;
	assign O_GPIO_OE = gpio_oe_ff;
	assign O_REGPIN = regpin_o_ff;
	assign O_REGPIN_OE = regpin_oe_ff;
	assign O_PAT_WE = pat_we_ff;
	assign O_PAT_ADDR = pat_a_ff;
	assign O_PAT_DATA = pat_d_ff;
endmodule

// File: testbench/sgai_top_asserts.sv
// Port-level checks of the GPIO and audio input block
module sgai_top_chk #(
	parameter logic [17:0] PD_HOLD_CYC = 18'h00014
) (
	// Clock, reset and power-down
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_POWER_DOWN_N,
	// Register ports
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic O_REG_RVALID,
	input wire logic I_RMT_WR,
	input wire logic I_RMT_RD,
	input wire logic O_RMT_RVALID,
	input wire logic O_RMT_BUSY,
	// Pins, link and pattern copy
	input wire logic [3:0] O_GPIO_OE,
	input wire logic [3:0] O_REGPIN_OE,
	input wire logic O_LINK_VALID,
	input wire logic I_LINK_READY,
	input wire logic [15:0] O_LINK_DATA,
	input wire logic O_PAT_WE,
	input wire logic [7:0] O_PAT_DATA
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST || !I_POWER_DOWN_N);
	sequence s_pat_wr;
		I_REG_WR && I_REG_ADDR == 8'h67;
	endsequence
	sequence s_rmt_rd;
		I_RMT_RD && !O_RMT_BUSY;
	endsequence
	sequence s_rmt_wr;
		I_RMT_WR && !O_RMT_BUSY;
	endsequence
	// Busy is bounded so a stuck remote slot shows up
	sequence s_busy_span;
		O_RMT_BUSY ##[1:40] !O_RMT_BUSY;
	endsequence
	chk_local_rd_ans: assert property (I_REG_RD |=> O_REG_RVALID)
		else $error("local read not answered");
	chk_rvalid_cause: assert property (O_REG_RVALID |-> $past(I_REG_RD))
		else $error("local read answer without request");
	chk_pat_copy: assert property (s_pat_wr |=> O_PAT_WE && O_PAT_DATA == $past(I_REG_WDATA))
		else $error("indirect data write not copied");
	chk_rmt_rd_ans: assert property (s_rmt_rd |-> ##[2:40] O_RMT_RVALID)
		else $error("remote read not answered");
	chk_rmt_wr_busy: assert property (s_rmt_wr |=> s_busy_span)
		else $error("remote write busy span wrong");
	chk_link_hold: assert property (O_LINK_VALID && !I_LINK_READY |=>
		O_LINK_VALID && $stable(O_LINK_DATA))
		else $error("link word changed while stalled");
	chk_gpio_word_form: assert property (O_LINK_VALID && O_LINK_DATA[15:14] == 2'h0 |->
		O_LINK_DATA[13:9] == 5'h00 && (O_LINK_DATA[3:0] & ~O_LINK_DATA[8:5]) == 4'h0)
		else $error("gpio link word malformed");
	chk_audio_word_form: assert property (O_LINK_VALID && O_LINK_DATA[15:14] != 2'h0 |->
		O_LINK_DATA[15:7] == 9'h080 && O_LINK_DATA[6:5] != 2'h0)
		else $error("audio link word malformed");
	chk_pd_clear: assert property (disable iff (I_SRST) !I_POWER_DOWN_N |=>
		O_GPIO_OE == 4'h0 && O_REGPIN_OE == 4'h0 && !O_LINK_VALID)
		else $error("power-down did not clear outputs");
endmodule

bind sgai_top sgai_top_chk #(.PD_HOLD_CYC(PD_HOLD_CYC)) u_chk (
	.I_CLK(I_CLK), .I_SRST(I_SRST), .I_POWER_DOWN_N(I_POWER_DOWN_N),
	.I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR),
	.I_REG_WDATA(I_REG_WDATA), .O_REG_RVALID(O_REG_RVALID), .I_RMT_WR(I_RMT_WR),
	.I_RMT_RD(I_RMT_RD), .O_RMT_RVALID(O_RMT_RVALID), .O_RMT_BUSY(O_RMT_BUSY),
	.O_GPIO_OE(O_GPIO_OE), .O_REGPIN_OE(O_REGPIN_OE), .O_LINK_VALID(O_LINK_VALID),
	.I_LINK_READY(I_LINK_READY), .O_LINK_DATA(O_LINK_DATA), .O_PAT_WE(O_PAT_WE),
	.O_PAT_DATA(O_PAT_DATA));

// File: testbench/sgai_partner.sv
// Paired deserializer model on the forward link
module sgai_partner (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Forward link
	input wire logic i_valid,
	input wire logic [15:0] i_data,
	output logic o_ready,
	// Test control
	input wire logic i_stall,
	input wire logic i_slow,
	// Back-channel pins and received state
	output logic [3:0] o_bc_gpio,
	output logic [15:0] o_gpio_word,
	output logic [15:0] o_audio_word,
	output int o_n_audio
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] cnt_ff;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_ff <= 7'h00;
			o_ready <= 1'b0;
			o_bc_gpio <= 4'h0;
			o_gpio_word <= 16'h0000;
			o_audio_word <= 16'h0000;
			o_n_audio <= 0;
		end else begin
			cnt_ff <= cnt_ff + 7'h01;
			// Slow mode accepts every other cycle
			o_ready <= !i_stall && !(i_slow && cnt_ff[0]);
			if (cnt_ff == 7'h7F) o_bc_gpio <= o_bc_gpio + 4'h3;
			if (i_valid && o_ready && i_data[15:14] == 2'h0) o_gpio_word <= i_data;
			if (i_valid && o_ready && i_data[15:14] == 2'h1) begin
				o_audio_word <= i_data;
				o_n_audio <= o_n_audio + 1;
			end
		end
	end
endmodule

// File: testbench/serializer_gpio_audio_input_test.sv
// Self-checking bench of the GPIO and audio input block
module serializer_gpio_audio_input_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_CLK = 1'b0, I_SRST = 1'b1, I_POWER_DOWN_N = 1'b1;
	logic I_REG_WR = 1'b0, I_REG_RD = 1'b0, I_RMT_WR = 1'b0, I_RMT_RD = 1'b0;
	logic [7:0] I_REG_ADDR = 8'h00, I_REG_WDATA = 8'h00, I_RMT_ADDR = 8'h00, I_RMT_WDATA = 8'h00;
	logic [3:0] I_GPIO = 4'h0, I_REGPIN = 4'h0, I_BC_GPIO, O_GPIO, O_GPIO_OE, O_REGPIN, O_REGPIN_OE;
	logic I_AUDIO_CLK = 1'b0, I_AUDIO_WC = 1'b0, I_LEGACY_COMPAT_MODE = 1'b0, I_OLDER_DESER = 1'b0;
	logic I_REPEATER_MODE = 1'b0, I_UP_SURROUND = 1'b0, stall = 1'b0, slow = 1'b0, aud_on = 1'b0;
	logic O_REG_RVALID, O_RMT_RVALID, O_RMT_BUSY, O_LINK_VALID, I_LINK_READY, O_PAT_WE;
	logic [7:0] O_REG_RDATA, O_RMT_RDATA, O_PAT_ADDR, O_PAT_DATA;
	logic [15:0] O_LINK_DATA, gw, aw;
	logic [8:0] acnt = 9'h000;
	logic [3:0] b;
	int miscompares = 0, n_compared = 0, cyc = 0, n_aud, n0;
	// {18-bit, older, audio ctrl, expected status}
	logic [23:0] at [9] = '{24'h000014, 24'h000118, 24'h0002FC, 24'h000434, 24'h000318,
		24'h010214, 24'h030234, 24'h030138, 24'h030034};
	sgai_top #(.PD_HOLD_CYC(18'h00014)) DUT (
		.I_CLK(I_CLK), .I_SRST(I_SRST), .I_POWER_DOWN_N(I_POWER_DOWN_N), .I_REG_WR(I_REG_WR),
		.I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
		.O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .I_RMT_WR(I_RMT_WR),
		.I_RMT_RD(I_RMT_RD), .I_RMT_ADDR(I_RMT_ADDR), .I_RMT_WDATA(I_RMT_WDATA),
		.O_RMT_RDATA(O_RMT_RDATA), .O_RMT_RVALID(O_RMT_RVALID), .O_RMT_BUSY(O_RMT_BUSY),
		.I_GPIO(I_GPIO), .O_GPIO(O_GPIO), .O_GPIO_OE(O_GPIO_OE), .I_REGPIN(I_REGPIN),
		.O_REGPIN(O_REGPIN), .O_REGPIN_OE(O_REGPIN_OE), .I_AUDIO_CLK(I_AUDIO_CLK),
		.I_AUDIO_WC(I_AUDIO_WC), .I_LEGACY_COMPAT_MODE(I_LEGACY_COMPAT_MODE),
		.I_OLDER_DESER(I_OLDER_DESER), .I_REPEATER_MODE(I_REPEATER_MODE),
		.I_UP_SURROUND(I_UP_SURROUND), .I_BC_GPIO(I_BC_GPIO), .O_LINK_VALID(O_LINK_VALID),
		.I_LINK_READY(I_LINK_READY), .O_LINK_DATA(O_LINK_DATA), .O_PAT_WE(O_PAT_WE),
		.O_PAT_ADDR(O_PAT_ADDR), .O_PAT_DATA(O_PAT_DATA));
	sgai_partner u_des (.i_clk(I_CLK), .i_rst(I_SRST), .i_valid(O_LINK_VALID),
		.i_data(O_LINK_DATA), .o_ready(I_LINK_READY), .i_stall(stall), .i_slow(slow),
		.o_bc_gpio(I_BC_GPIO), .o_gpio_word(gw), .o_audio_word(aw), .o_n_audio(n_aud));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #4 I_CLK = ~I_CLK;
	end
	// 16-cycle bit clock, about 7.8 MHz
	always @(posedge I_CLK) begin
		if (aud_on) begin
			acnt <= acnt + 9'h001;
			I_AUDIO_CLK <= acnt[3];
			I_AUDIO_WC <= acnt[8];
		end
	end
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			miscompares++;
			$display("CHECK FAILED t=%0t timeout", $time);
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
		n_compared++;
		if ((g & m) !== (e & m)) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge I_CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		I_REG_WR <= 1'b1;
		I_REG_ADDR <= a;
		I_REG_WDATA <= d;
		@(posedge I_CLK);
		I_REG_WR <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge I_CLK);
		I_REG_RD <= 1'b1;
		I_REG_ADDR <= a;
		@(posedge I_CLK);
		I_REG_RD <= 1'b0;
		#1;
		cmp({O_REG_RVALID, 7'h00, O_REG_RDATA}, {8'h80, e}, {8'h80, m});
	endtask
	// Remote access, answer awaited under a bound
	task automatic rm(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		I_RMT_WR <= w;
		I_RMT_RD <= !w;
		I_RMT_ADDR <= a;
		I_RMT_WDATA <= d;
		@(posedge I_CLK);
		I_RMT_WR <= 1'b0;
		I_RMT_RD <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			#1;
			if (w ? O_RMT_BUSY === 1'b0 : O_RMT_RVALID === 1'b1) break;
			@(posedge I_CLK);
		end
		cmp({7'h00, w ? !O_RMT_BUSY : O_RMT_RVALID, w ? d : O_RMT_RDATA}, {8'h01, d}, 16'h01FF);
	endtask
	task automatic pd(input int n);
		@(posedge I_CLK);
		I_POWER_DOWN_N <= 1'b0;
		cy(n);
		I_POWER_DOWN_N <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cy(8);
		I_SRST <= 1'b0;
		rc(8'h0D, 8'h00, 8'hFF);
		rc(8'h55, 8'h00, 8'hFF);
		wr(8'h1C, 8'hFF);
		rc(8'h1C, 8'h00, 8'hFF);
		$display("test reset done");
		wr(8'h0D, 8'h01);
		wr(8'h0E, 8'h99);
		wr(8'h0F, 8'h91);
		wr(8'h10, 8'h10);
		wr(8'h11, 8'h09);
		cy(2);
		cmp({O_GPIO_OE, O_GPIO, O_REGPIN_OE, O_REGPIN}, 16'hF6D9, 16'hFFFF);
		rc(8'h71, 8'h04, 8'hFC);
		$display("test local drive done");
		rm(1'b1, 8'h0D, 8'h03);
		wr(8'h0E, 8'h33);
		wr(8'h0F, 8'h33);
		wr(8'h10, 8'h33);
		wr(8'h11, 8'h03);
		for (int k = 0; k < 2; k++) begin
			@(posedge I_CLK);
			I_GPIO <= k ? 4'h5 : 4'hA;
			I_REGPIN <= k ? 4'hA : 4'h5;
			cy(4);
			rc(8'h1C, k ? 8'h45 : 8'hAA, 8'hFF);
			rm(1'b0, 8'h1D, 8'(k));
		end
		cy(60);
		cmp(gw, 16'h01E5, 16'hFFFF);
		@(posedge I_CLK);
		I_OLDER_DESER <= 1'b1;
		cy(60);
		cmp(gw, 16'h0000, 16'hFFFF);
		wr(8'h12, 8'h04);
		cy(60);
		cmp(gw, 16'h01F5, 16'hFFFF);
		wr(8'h0D, 8'h05);
		for (int k = 0; k < 3; k++) begin
			cy(90);
			#1;
			b = I_BC_GPIO;
			@(posedge I_CLK);
			#1;
			cmp(16'({O_GPIO_OE[0], O_GPIO[0]}), 16'({1'b1, b[0]}), 16'h0003);
		end
		@(posedge I_CLK);
		I_LEGACY_COMPAT_MODE <= 1'b1;
		cy(40);
		cmp(16'(O_GPIO_OE[0]), 16'h0000, 16'h0001);
		rc(8'h71, 8'h00, 8'h0C);
		I_LEGACY_COMPAT_MODE <= 1'b0;
		$display("test link gpio done");
		pd(24);
		rc(8'h0D, 8'h00, 8'hFF);
		rc(8'h12, 8'h00, 8'hFF);
		rc(8'h71, 8'h00, 8'h02);
		pd(5);
		rc(8'h71, 8'h02, 8'h02);
		rc(8'h71, 8'h00, 8'h02);
		$display("test power-down done");
		aud_on <= 1'b1;
		{I_GPIO, I_REGPIN} <= 8'hFF;
		for (int i = 0; i < 9; i++) begin
			@(posedge I_CLK);
			I_OLDER_DESER <= at[i][16];
			wr(8'h12, {5'h00, at[i][17], 2'h0});
			wr(8'h70, at[i][15:8]);
			cy(60);
			rc(8'h71, at[i][7:0], 8'hFC);
			cmp(16'({aw[6:5], aw[3:0]}), 16'({at[i][3:2], at[i][7:4]}), 16'h003F);
		end
		I_OLDER_DESER <= 1'b0;
		I_REPEATER_MODE <= 1'b1;
		wr(8'h70, 8'h01);
		cy(30);
		n0 = n_aud;
		cy(100);
		cmp(16'(n_aud == n0), 16'h0001, 16'h0001);
		wr(8'h70, 8'h09);
		cy(100);
		cmp(16'(n_aud > n0), 16'h0001, 16'h0001);
		I_UP_SURROUND <= 1'b1;
		cy(60);
		rc(8'h71, 8'hFC, 8'hFC);
		cmp(16'(aw[6:5]), 16'h0003, 16'h0003);
		$display("test audio modes done");
		// Stall until the FIFO refuses
		n0 = n_aud;
		stall <= 1'b1;
		cy(400);
		rc(8'h71, 8'h01, 8'h01);
		stall <= 1'b0;
		slow <= 1'b1;
		for (int i = 0; i < 300 && n_aud - n0 < 17; i++) @(posedge I_CLK);
		cmp(16'(n_aud - n0 >= 17), 16'h0001, 16'h0001);
		rc(8'h71, 8'hFC, 8'hFC);
		rc(8'h71, 8'h00, 8'h01);
		$display("test fifo done");
		wr(8'h66, 8'h12);
		wr(8'h67, 8'hA5);
		#1;
		cmp({O_PAT_WE, 7'h00, O_PAT_ADDR}, 16'h8012, 16'hFFFF);
		rc(8'h66, 8'h12, 8'hFF);
		rc(8'h67, 8'hA5, 8'hFF);
		$display("test pattern done");
		stop_test();
	end
endmodule
